// File: adc_pointer_result_alert_regs.sv
// Pointer, conversion result and alert status register bank
// Function
// - First data byte of every write is stored in the register pointer.
// - Only the three low pointer bits are kept; host writes upper bits zero.
// - Reset clears the pointer, selecting the conversion result register.
// - Pointer routes later bytes to one of eight data registers.
// - Result register is read-only; reading it starts a conversion in normal mode.
// - Eight-bit straight binary result sits in bits 11 to 4.
// - Result bits 14 to 12 and 3 to 0 read as zero.
// - Result bit 15 is flag enable and-ed with either alert flag.
// - Alert status flags are active high, one means limit violated.
// - Over-range flag, bit 1, sets when a result exceeds the upper limit.
// - Under-range flag, bit 0, sets when a result is below the lower limit.
// - Writing one to a flag clears it.
// - Without hold, over-range clears when result drops below upper minus hysteresis.
// - Without hold, under-range clears when result rises above lower plus hysteresis.
// - With hold set, flags clear only by a host write of one.
// - Alert status bits 7 to 2 read as zero; host writes zeros.
// - Configuration bit 3 gates the summary alert bit in the result.
// - Configuration bit 4 selects alert hold.
`timescale 1ns/100ps
`default_nettype none
module adc_pointer_result_alert_regs (
  // Clock, reset and enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clock_enable,
  // Write bytes from the serial controller
  input wire logic wr_start,
  input wire logic wr_valid,
  input wire logic [7:0] wr_byte,
  // Read bytes to the serial controller
  input wire logic rd_start,
  input wire logic rd_req,
  output logic [7:0] rd_byte,
  output logic rd_byte_valid,
  // Converter core
  input wire logic conv_done,
  input wire logic [7:0] conv_data,
  output logic conv_start,
  // Status view
  output logic [1:0] alert_flags
);
  import adc_regs_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [PTR_WIDTH-1:0] pointer_reg;
  logic [1:0] wr_index_reg;
  logic [7:0] wr_hi_reg;
  logic rd_index_reg;
  logic [7:0] result_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [7:0] config_reg;
  logic [7:0] field_reg [FIELD_COUNT];
  logic wr_take;
  logic rd_take;
  logic wr_ptr_byte;
  logic wr_data_byte;
  logic is_wide;
  logic [15:0] read_word;
  logic hold;
  logic normal_mode;
  logic [8:0] over_clear_level;
  logic [8:0] under_clear_level;

  // Strobes only count while enabled
  assign wr_take = clock_enable & wr_valid & ~wr_start;
  assign rd_take = clock_enable & rd_req & ~rd_start;
  assign wr_ptr_byte = wr_take & (wr_index_reg == 2'h0);
  assign wr_data_byte = wr_take & (wr_index_reg != 2'h0);
  assign is_wide = (pointer_reg != PTR_STATUS) && (pointer_reg != PTR_CONFIG);
  assign hold = config_reg[CFG_HOLD_BIT];
  assign normal_mode = (config_reg[7:CFG_CYCLE_LSB] == 3'h0);

  // ****************************************
  // Pointer and write byte sequencing
  // ****************************************
  // Pointer loads from first write byte, kept across transactions
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pointer_reg <= PTR_RESET;
    end else if (wr_ptr_byte) begin
      pointer_reg <= wr_byte[PTR_WIDTH-1:0];
    end
  end

  // Byte position inside a write transaction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_index_reg <= 2'h0;
      wr_hi_reg <= 8'h00;
    end else if (clock_enable && wr_start) begin
      wr_index_reg <= 2'h0;
    end else if (wr_take) begin
      if (wr_index_reg == 2'h1 && is_wide) begin
        wr_hi_reg <= wr_byte;
        wr_index_reg <= 2'h2;
      end else begin
        wr_index_reg <= 2'h1;
      end
    end
  end

  // ****************************************
  // Limit, hysteresis and extreme fields
  // ****************************************
  // Low byte of a wide write commits bits 11 to 4
  for (genvar i = 0; i < FIELD_COUNT; i++) begin : g_field
    localparam logic [2:0] PTR_I = 3'(FIELD_FIRST + i);
    localparam logic [7:0] RST_I = (i == 0) ? LOW_RESET : (i == 1) ? HIGH_RESET :
                                   (i == 2) ? HYST_RESET : (i == 3) ? LOWEST_RESET :
                                   HIGHEST_RESET;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        field_reg[i] <= RST_I;
      end else if (wr_data_byte && wr_index_reg == 2'h2 && pointer_reg == PTR_I) begin
        field_reg[i] <= {wr_hi_reg[3:0], wr_byte[7:4]};
      end
    end
  end

  // Configuration byte, reserved bit kept zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      config_reg <= CONFIG_RESET;
    end else if (wr_data_byte && wr_index_reg == 2'h1 && pointer_reg == PTR_CONFIG) begin
      config_reg <= wr_byte & ~(8'h01 << CFG_RSVD_BIT);
    end
  end

  // ****************************************
  // Conversion result and alert flags
  // ****************************************
  // Result stored on each finished conversion, never by writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      result_reg <= RESULT_RESET;
    end else if (clock_enable && conv_done) begin
      result_reg <= conv_data;
    end
  end

  // Self-clear thresholds in nine bits to avoid wrap
  assign over_clear_level = {1'b0, field_reg[PTR_HIGH - 3'(FIELD_FIRST)]} -
                            {1'b0, field_reg[PTR_HYST - 3'(FIELD_FIRST)]};
  assign under_clear_level = {1'b0, field_reg[PTR_LOW - 3'(FIELD_FIRST)]} +
                             {1'b0, field_reg[PTR_HYST - 3'(FIELD_FIRST)]};

  // Flag update: clear sources first, set wins last
  always_comb begin
    status_next = status_reg;
    if (wr_data_byte && wr_index_reg == 2'h1 && pointer_reg == PTR_STATUS) begin
      status_next = status_reg & ~wr_byte[1:0];
    end
    if (clock_enable && conv_done && !hold) begin
      if (!over_clear_level[8] && {1'b0, conv_data} < over_clear_level) begin
        status_next[STAT_OVER_BIT] = 1'b0;
      end
      if ({1'b0, conv_data} > under_clear_level) begin
        status_next[STAT_UNDER_BIT] = 1'b0;
      end
    end
    if (clock_enable && conv_done) begin
      if (conv_data > field_reg[PTR_HIGH - 3'(FIELD_FIRST)]) begin
        status_next[STAT_OVER_BIT] = 1'b1;
      end
      if (conv_data < field_reg[PTR_LOW - 3'(FIELD_FIRST)]) begin
        status_next[STAT_UNDER_BIT] = 1'b1;
      end
    end
  end

  // Alert flag register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= STATUS_RESET;
    end else begin
      status_reg <= status_next;
    end
  end

  // Status mirror for the outside
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alert_flags <= STATUS_RESET;
    end else begin
      alert_flags <= status_next;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Word selected by the pointer
  always_comb begin
    case (pointer_reg)
      PTR_RESULT: begin
        read_word = {(config_reg[CFG_FLAG_EN_BIT] & (|status_reg)), 3'h0,
                     result_reg, 4'h0};
      end
      PTR_STATUS: read_word = {8'h00, 6'h00, status_reg};
      PTR_CONFIG: read_word = {8'h00, config_reg};
      default: read_word = {4'h0, field_reg[pointer_reg - 3'(FIELD_FIRST)], 4'h0};
    endcase
  end

  // Byte position inside a read transaction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_index_reg <= 1'b0;
    end else if (clock_enable && rd_start) begin
      rd_index_reg <= 1'b0;
    end else if (rd_take && is_wide) begin
      rd_index_reg <= ~rd_index_reg;
    end
  end

  // Answer byte, high byte first for wide registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_byte <= 8'h00;
      rd_byte_valid <= 1'b0;
    end else if (clock_enable) begin
      rd_byte_valid <= rd_take;
      if (rd_take) begin
        rd_byte <= (is_wide && !rd_index_reg) ? read_word[15:8] : read_word[7:0];
      end
    end
  end

  // New conversion once the result's low byte went out
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      conv_start <= 1'b0;
    end else if (clock_enable) begin
      conv_start <= rd_take && pointer_reg == PTR_RESULT && rd_index_reg && normal_mode;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  ptr_load_a: assert property (@(posedge clock) disable iff (!reset_n)
    wr_ptr_byte |=> pointer_reg == $past(wr_byte[2:0]))
    else $error("pointer not loaded from first write byte");
  ptr_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    !wr_ptr_byte |=> $stable(pointer_reg))
    else $error("pointer changed without a pointer byte");
  result_ro_a: assert property (@(posedge clock) disable iff (!reset_n)
    !(clock_enable && conv_done) |=> $stable(result_reg))
    else $error("result changed without a conversion");
  conv_kick_a: assert property (@(posedge clock) disable iff (!reset_n)
    rd_take && pointer_reg == PTR_RESULT && rd_index_reg && normal_mode |=> conv_start)
    else $error("result read did not start a conversion");
  res_high_a: assert property (@(posedge clock) disable iff (!reset_n)
    rd_take && pointer_reg == PTR_RESULT && !rd_index_reg |=>
    rd_byte_valid && rd_byte == {$past(config_reg[3] & |status_reg), 3'h0,
                                 $past(result_reg[7:4])})
    else $error("result high byte wrong");
  res_low_a: assert property (@(posedge clock) disable iff (!reset_n)
    rd_take && pointer_reg == PTR_RESULT && rd_index_reg |=>
    rd_byte == {$past(result_reg[3:0]), 4'h0})
    else $error("result low byte wrong");
  over_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && conv_done && conv_data > field_reg[1] |=> status_reg[1])
    else $error("over-range flag not set");
  under_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && conv_done && conv_data < field_reg[0] |=> status_reg[0])
    else $error("under-range flag not set");
  flag_w1c_a: assert property (@(posedge clock) disable iff (!reset_n)
    wr_data_byte && wr_index_reg == 2'h1 && pointer_reg == PTR_STATUS &&
    wr_byte[1] && !conv_done |=> !status_reg[1])
    else $error("over-range flag not cleared by write of one");
  hold_keep_a: assert property (@(posedge clock) disable iff (!reset_n)
    hold && !(wr_data_byte && pointer_reg == PTR_STATUS) && status_reg[0] |=> status_reg[0])
    else $error("held flag cleared on its own");
  status_rsvd_a: assert property (@(posedge clock) disable iff (!reset_n)
    rd_take && pointer_reg == PTR_STATUS |=> rd_byte[7:2] == 6'h00)
    else $error("status reserved bits not zero");
  // Self-clear and gating checks in terms of the stored fields, then the under-range write-one-clear check
  over_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && conv_done && !hold &&
    {1'b0, conv_data} + {1'b0, field_reg[2]} < {1'b0, field_reg[1]} |=> !status_reg[1])
    else $error("over-range flag did not self-clear");
  under_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
    clock_enable && conv_done && !hold &&
    {1'b0, conv_data} > {1'b0, field_reg[0]} + {1'b0, field_reg[2]} |=> !status_reg[0])
    else $error("under-range flag did not self-clear");
  flag_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    rd_take && pointer_reg == PTR_RESULT && !rd_index_reg && !config_reg[3] |=> !rd_byte[7])
    else $error("summary alert bit shown while disabled");
  under_w1c_a: assert property (@(posedge clock) disable iff (!reset_n)
    wr_data_byte && wr_index_reg == 2'h1 && pointer_reg == PTR_STATUS &&
    wr_byte[0] && !conv_done |=> !status_reg[0])
    else $error("under-range flag not cleared by write of one");
  result_read_c: cover property (@(posedge clock) disable iff (!reset_n)
    rd_take && pointer_reg == PTR_RESULT && !rd_index_reg ##1 rd_take ##1 conv_start);
  over_alert_c: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(status_reg[1]));
  self_clear_c: cover property (@(posedge clock) disable iff (!reset_n)
    !hold && $fell(status_reg[0]));
  limit_write_c: cover property (@(posedge clock) disable iff (!reset_n)
    wr_data_byte && wr_index_reg == 2'h2 && pointer_reg == PTR_HIGH);
endmodule
`default_nettype wire

// File: adc_pointer_result_alert_regs_tb.sv
// Self-checking bench for the pointer, result and alert register bank
`timescale 1ns/100ps
`default_nettype none
module adc_pointer_result_alert_regs_tb;
  import adc_regs_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clock_enable = 1'b1;
  logic conv_done = 1'b0;
  logic [7:0] conv_data = 8'h00;
  logic wr_start, wr_valid, rd_start, rd_req, rd_byte_valid, conv_start;
  logic [7:0] wr_byte, rd_byte, cfg, d;
  logic [1:0] alert_flags, fl, w;
  logic [7:0] modes [4] = '{8'h08, 8'h18, 8'h10, 8'h28};
  logic [8:0] exp[$];
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 95889;
  int lo = 32;
  int hi = 192;
  int hy = 16;

  // Clock at 40 MHz
  always #12.5 clock = ~clock;

  adc_pointer_result_alert_regs DUT (.clock(clock), .reset_n(reset_n),
    .clock_enable(clock_enable), .wr_start(wr_start), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_start(rd_start), .rd_req(rd_req), .rd_byte(rd_byte),
    .rd_byte_valid(rd_byte_valid), .conv_done(conv_done), .conv_data(conv_data),
    .conv_start(conv_start), .alert_flags(alert_flags));

  host_model host (.clock(clock), .wr_start(wr_start), .wr_valid(wr_valid),
    .wr_byte(wr_byte), .rd_start(rd_start), .rd_req(rd_req));

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] want);
    checks++;
    if (seen !== want) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One conversion and the matching flag update of the model
  task automatic convert;
    d = 8'($random(seed));
    @(posedge clock);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clock);
    conv_done <= 1'b0;
    conv_data <= ~d;
    if (!cfg[4]) begin
      if (hi >= hy && d < hi - hy) fl[1] = 1'b0;
      if (d > lo + hy) fl[0] = 1'b0;
    end
    if (d > hi) fl[1] = 1'b1;
    if (d < lo) fl[0] = 1'b1;
    @(posedge clock);
    #1 chk("alert_flags", {7'h00, alert_flags}, {7'h00, fl});
  endtask

  // Point at the result and read both bytes
  task automatic read_result;
    host.wr(PTR_RESULT, 16'h0000, 0);
    exp.push_back({1'b0, cfg[3] & (fl != 2'h0), 3'h0, d[7:4]});
    exp.push_back({cfg[7:5] == 3'h0, d[3:0], 4'h0});
    host.rd(2);
    repeat (2) @(posedge clock);
  endtask

  // Random write-one-to-clear, then status readback
  task automatic status_w1c;
    w = 2'($random(seed));
    host.wr(PTR_STATUS, {14'h0000, w}, 1);
    fl = fl & ~w;
    #1 chk("cleared flags", {7'h00, alert_flags}, {7'h00, fl});
    exp.push_back({3'h0, 4'h0, fl});
    host.rd(1);
    repeat (2) @(posedge clock);
  endtask

  // Compares each answered byte and conversion strobe with the oldest note
  always @(negedge clock) begin
    if (rd_byte_valid === 1'b1) begin
      if (exp.size() == 0) begin
        chk("unexpected read", 9'h1ff, 9'h000);
      end else begin
        chk("read byte", {conv_start, rd_byte}, exp.pop_front());
      end
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    cfg = 8'h00;
    fl = 2'h0;
    d = 8'h00;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    exp.push_back(9'h000);
    exp.push_back(9'h100);
    host.rd(2);
    repeat (2) @(posedge clock);
    host.wr(PTR_LOW, 16'h0200, 2);
    host.wr(PTR_HIGH, 16'h0c00, 2);
    host.wr(PTR_HYST, 16'h0100, 2);
    // Frozen block ignores an out-of-range conversion
    @(posedge clock);
    clock_enable <= 1'b0;
    conv_done <= 1'b1;
    conv_data <= 8'hff;
    repeat (2) @(posedge clock);
    conv_done <= 1'b0;
    clock_enable <= 1'b1;
    @(posedge clock);
    #1 chk("frozen flags", {7'h00, alert_flags}, {7'h00, fl});
    for (int i = 0; i < 48; i++) begin
      if (i % 12 == 0) begin
        cfg = modes[i / 12];
        host.wr(PTR_CONFIG, {8'h00, cfg}, 1);
      end
      convert();
      read_result();
      if (i % 3 == 0) status_w1c();
    end
    chk("pending reads", 9'(exp.size()), 9'h000);
    end_sim();
  end
endmodule
`default_nettype wire

// File: adc_regs_pkg.sv
// Constants for the converter pointer, result and alert register bank
`default_nettype none
package adc_regs_pkg;
  // ****************************************
  // Pointer values selecting the data registers
  // ****************************************
  localparam logic [2:0] PTR_RESULT = 3'h0;
  localparam logic [2:0] PTR_STATUS = 3'h1;
  localparam logic [2:0] PTR_CONFIG = 3'h2;
  localparam logic [2:0] PTR_LOW = 3'h3;
  localparam logic [2:0] PTR_HIGH = 3'h4;
  localparam logic [2:0] PTR_HYST = 3'h5;
  localparam logic [2:0] PTR_LOWEST = 3'h6;
  localparam logic [2:0] PTR_HIGHEST = 3'h7;
  localparam int PTR_WIDTH = 3;
  localparam int FIELD_FIRST = 3; // First pointer of the 8-bit limit fields
  localparam int FIELD_COUNT = 5; // Low, high, hysteresis, lowest, highest

  // ****************************************
  // Field positions
  // ****************************************
  localparam int RES_FLAG_BIT = 15;
  localparam int RES_DATA_LSB = 4;
  localparam int STAT_UNDER_BIT = 0;
  localparam int STAT_OVER_BIT = 1;
  localparam int CFG_RSVD_BIT = 1;
  localparam int CFG_FLAG_EN_BIT = 3;
  localparam int CFG_HOLD_BIT = 4;
  localparam int CFG_CYCLE_LSB = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [2:0] PTR_RESET = 3'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [1:0] STATUS_RESET = 2'h0;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] LOW_RESET = 8'h00;
  localparam logic [7:0] HIGH_RESET = 8'hff;
  localparam logic [7:0] HYST_RESET = 8'h00;
  localparam logic [7:0] LOWEST_RESET = 8'h00;
  localparam logic [7:0] HIGHEST_RESET = 8'h00;
endpackage
`default_nettype wire

// File: host_model.sv
// Host-side byte driver standing in for the serial bus controller
`timescale 1ns/100ps
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Write link
  output logic wr_start,
  output logic wr_valid,
  output logic [7:0] wr_byte,
  // Read link
  output logic rd_start,
  output logic rd_req
);
  // Idle levels at time zero
  initial begin
    wr_start = 1'b0;
    wr_valid = 1'b0;
    wr_byte = 8'h5a;
    rd_start = 1'b0;
    rd_req = 1'b0;
  end

  // Write frame: pointer byte, then n bytes of val, high byte first
  task automatic wr(input logic [2:0] ptr, input logic [15:0] val, input int n);
    @(posedge clock);
    wr_start <= 1'b1;
    @(posedge clock);
    wr_start <= 1'b0;
    wr_valid <= 1'b1;
    wr_byte <= {5'h00, ptr};
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge clock);
      wr_byte <= val[8*i +: 8];
    end
    @(posedge clock);
    wr_valid <= 1'b0;
    wr_byte <= ~wr_byte; // Released line shows no stale byte
  endtask

  // Read frame: start, then n back-to-back byte requests
  task automatic rd(input int n);
    @(posedge clock);
    rd_start <= 1'b1;
    @(posedge clock);
    rd_start <= 1'b0;
    rd_req <= 1'b1;
    repeat (n) @(posedge clock);
    rd_req <= 1'b0;
  endtask
endmodule
`default_nettype wire
